// ### rtl/nvm_program_control.sv
// Program and erase control for the one-time-programmable and byte-erasable arrays.
// Operation
// - Latch clear forces the OTP program enable to zero.
// - While OTP latched, reads mismatch, vectors and boot routines are blocked.
// - Stop, power-on and external reset clear the OTP latch.
// - Erased OTP byte reads zero; reprogramming only adds one bits.
// - Latched OTP holds one address group plus up to eight data bytes.
// - Program enable sets only after latch and a byte; only latch clear clears it.
// - OTP latch and program bits encode read, load and program states.
// - Erase select picks erase or program; frozen once address is latched.
// - Clearing EEPROM latch clears erase and pump; stop and resets clear it.
// - Pump sets only after data selected; cleared only by latch clear.
// - Erase, latch and pump bits encode five EEPROM states.
// - Reset pin held 16 cycles when option set, else 4064.
// - Watchdog runs after reset when option set, except in bootstrap.
// - Watchdog keeps counting in wait mode only when option set.
// - Port pull-downs act only on pins configured as inputs.
// - Lowest 32 bytes never protected; upper region writes fail when locked.
// - Unlock bit written zero only while latched; unlock holds until reset.
// - Upper-region protection is off in bootstrap mode.
// - Content lock zero blocks non-user mode; changes act after reset.
`timescale 1ns/1ps
`default_nettype none
module nvm_program_control (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic stop_entry,
   input wire logic wait_mode,
   input wire logic bootstrap_mode,
   input wire logic array_blank,
   input wire nvm_pkg::factory_opt_t factory_options,
   input wire logic [7:0] port_b_dir,
   input wire logic [7:0] port_c_dir,
   output logic otp_program_enable,
   output logic otp_fetch_inhibit,
   output logic eeprom_pump_on,
   output logic non_user_block,
   output logic reset_pin_hold,
   output logic watchdog_run,
   output logic [7:0] port_b_pulldown_en,
   output logic [7:0] port_c_pulldown_en
);
   nvm_pkg::otp_state_t otp_state;
   nvm_pkg::ee_state_t ee_state;
   nvm_pkg::factory_opt_t opt;
   logic [7:0] otp_mem [0:255];
   logic [7:0] ee_mem [0:255];
   logic [7:0] otp_buf [0:7];
   logic [7:0] otp_mask;
   logic [4:0] otp_group;
   logic [7:0] ee_addr;
   logic [7:0] ee_data;
   logic ee_sel;
   logic unlock_eff;
   logic wd_armed;
   logic [13:0] idx;
   logic wr_go;
   logic wr_ctl;
   logic wr_otp;
   logic wr_ee;
   logic [7:0] wd;
   logic otp_commit;
   logic ee_commit;
   logic ee_protected;
   logic [7:0] next_rdata;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // The upper bits of an index pick a 256-byte window.
   function automatic logic in_win(input logic [13:0] a, input logic [13:0] base);
      in_win = (a[13:8] == base[13:8]);
   endfunction

   assign idx = avs_address[15:2];
   assign wd = avs_writedata[7:0];
   assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign wr_ctl = wr_go && (idx == nvm_pkg::CTL_IDX);
   assign wr_otp = wr_go && in_win(idx, nvm_pkg::OTP_BASE);
   assign wr_ee = wr_go && in_win(idx, nvm_pkg::EE_BASE);
   assign otp_commit = wr_ctl && !stop_entry && (otp_state == nvm_pkg::OTP_PROG)
      && !wd[nvm_pkg::OTP_LATCH_BIT];
   assign ee_commit = wr_ctl && !stop_entry && ee_state[nvm_pkg::EE_PUMP_BIT]
      && !wd[nvm_pkg::EE_LATCH_BIT];
   assign ee_protected = (ee_addr >= nvm_pkg::EE_UPPER_OFS) && !unlock_eff && !bootstrap_mode;

   // Bus slave: one wait state, so every access answers on the second edge.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= 1'b1;
         if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= {24'h00_0000, next_rdata};
         end
      end
   end

   always_comb begin
      next_rdata = nvm_pkg::RESET_BYTE;
      if (idx == nvm_pkg::CTL_IDX) begin
         next_rdata = {2'b00, otp_state, 1'b0, ee_state};
      end else if (idx == nvm_pkg::MOR_IDX) begin
         next_rdata = {3'b000, opt};
      end else if (in_win(idx, nvm_pkg::EE_BASE)) begin
         next_rdata = ee_mem[idx[7:0]];
      end else if (in_win(idx, nvm_pkg::OTP_BASE)) begin
         next_rdata = (otp_state == nvm_pkg::OTP_READ) ? otp_mem[idx[7:0]] : ~otp_mem[idx[7:0]];
      end
   end

   // OTP state: the enum codes are the latch and program bits themselves.
   always_ff @(posedge ref_clk) begin
      if (sys_rst || stop_entry) begin
         otp_state <= nvm_pkg::OTP_READ;
      end else if (wr_ctl) begin
         case (otp_state)
            nvm_pkg::OTP_READ: begin
               if (wd[nvm_pkg::OTP_LATCH_BIT]) begin
                  otp_state <= nvm_pkg::OTP_LOAD;
               end
            end
            nvm_pkg::OTP_LOAD: begin
               if (!wd[nvm_pkg::OTP_LATCH_BIT]) begin
                  otp_state <= nvm_pkg::OTP_READ;
               end else if (wd[nvm_pkg::OTP_PGM_BIT] && (otp_mask != 8'h00)) begin
                  otp_state <= nvm_pkg::OTP_PROG;
               end
            end
            nvm_pkg::OTP_PROG: begin
               if (!wd[nvm_pkg::OTP_LATCH_BIT]) begin
                  otp_state <= nvm_pkg::OTP_READ;
               end
            end
            default: begin
               otp_state <= nvm_pkg::OTP_READ;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || stop_entry || (otp_state == nvm_pkg::OTP_READ)) begin
         otp_mask <= 8'h00;
         otp_group <= 5'h00;
      end else if (wr_otp && (otp_state == nvm_pkg::OTP_LOAD)) begin
         // low three bits pick the byte
         otp_buf[idx[2:0]] <= wd;
         otp_mask[idx[2:0]] <= 1'b1;
         if (otp_mask == 8'h00) begin
            otp_group <= idx[7:3];
         end
      end
   end

   // The arrays are nonvolatile, so reset leaves them alone.
   always_ff @(posedge ref_clk) begin
      if (array_blank) begin
         for (int i = 0; i < 256; i++) begin
            otp_mem[i] <= nvm_pkg::OTP_ERASED;
         end
      end else if (otp_commit) begin
         for (int i = 0; i <= int'(nvm_pkg::GROUP_SIZE_M1); i++) begin
            if (otp_mask[i]) begin
               otp_mem[{otp_group, 3'(i)}] <= otp_mem[{otp_group, 3'(i)}] | otp_buf[i];
            end
         end
      end
   end

   // EEPROM state: the enum codes are the erase, latch and pump bits.
   always_ff @(posedge ref_clk) begin
      if (sys_rst || stop_entry) begin
         ee_state <= nvm_pkg::EE_READ;
      end else if (wr_ctl) begin
         case (ee_state)
            nvm_pkg::EE_READ: begin
               if (wd[nvm_pkg::EE_LATCH_BIT]) begin
                  ee_state <= wd[nvm_pkg::EE_ERA_BIT] ? nvm_pkg::EE_LOAD_ERASE
                     : nvm_pkg::EE_LOAD_PROG;
               end
            end
            nvm_pkg::EE_LOAD_PROG, nvm_pkg::EE_LOAD_ERASE: begin
               // latch clear drops erase and pump
               if (!wd[nvm_pkg::EE_LATCH_BIT]) begin
                  ee_state <= nvm_pkg::EE_READ;
               end else begin
                  ee_state <= nvm_pkg::ee_state_t'({
                     ee_sel ? ee_state[nvm_pkg::EE_ERA_BIT] : wd[nvm_pkg::EE_ERA_BIT],
                     1'b1,
                     ee_sel && wd[nvm_pkg::EE_PUMP_BIT]});
               end
            end
            nvm_pkg::EE_PROG, nvm_pkg::EE_ERASE: begin
               // only latch clear stops the pump
               if (!wd[nvm_pkg::EE_LATCH_BIT]) begin
                  ee_state <= nvm_pkg::EE_READ;
               end
            end
            default: begin
               ee_state <= nvm_pkg::EE_READ;
            end
         endcase
      end
   end

   // EEPROM address and data latch for one byte operation.
   always_ff @(posedge ref_clk) begin
      if (sys_rst || stop_entry || (ee_state == nvm_pkg::EE_READ)) begin
         ee_sel <= 1'b0;
         ee_addr <= 8'h00;
         ee_data <= nvm_pkg::EE_ERASED;
      end else if (wr_ee && !ee_state[nvm_pkg::EE_PUMP_BIT]) begin
         // options byte written only while latched
         ee_sel <= 1'b1;
         ee_addr <= idx[7:0];
         ee_data <= wd;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (array_blank) begin
         for (int i = 0; i < 256; i++) begin
            ee_mem[i] <= nvm_pkg::EE_ERASED;
         end
      end else if (ee_commit && ee_sel && !ee_protected) begin
         ee_mem[ee_addr] <= ee_state[nvm_pkg::EE_ERA_BIT] ? nvm_pkg::EE_ERASED
            : (ee_mem[ee_addr] & ee_data);
      end
   end
   // Option bits are sampled only while reset is applied, so a fresh value in the
   // options byte or the strap waits for the next reset.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         opt <= factory_options;
         unlock_eff <= ee_mem[nvm_pkg::OPT_OFS][nvm_pkg::UNLOCK_BIT];
         non_user_block <= !ee_mem[nvm_pkg::OPT_OFS][nvm_pkg::LOCK_BIT];
         wd_armed <= factory_options.watchdog_after_reset && !bootstrap_mode;
      end
   end
   // Outputs registered for glitch-free pins.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         otp_program_enable <= 1'b0;
         otp_fetch_inhibit <= 1'b0;
         eeprom_pump_on <= 1'b0;
         watchdog_run <= 1'b0;
         port_b_pulldown_en <= 8'h00;
         port_c_pulldown_en <= 8'h00;
      end else begin
         otp_program_enable <= (otp_state == nvm_pkg::OTP_PROG);
         otp_fetch_inhibit <= (otp_state != nvm_pkg::OTP_READ);
         eeprom_pump_on <= ee_state[nvm_pkg::EE_PUMP_BIT];
         watchdog_run <= wd_armed && (!wait_mode || opt.watchdog_in_wait);
         port_b_pulldown_en <= {8{opt.port_b_pulldown}} & ~port_b_dir;
         port_c_pulldown_en <= {8{opt.port_c_pulldown}} & ~port_c_dir;
      end
   end
   reset_hold_timer u_hold (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .short_hold(opt.reset_hold_select),
      .hold(reset_pin_hold)
   );

   property p_pgm_needs_latch;
      otp_program_enable |-> otp_fetch_inhibit;
   endproperty
   a_pgm_needs_latch: assert property (p_pgm_needs_latch)
      else $error("Program enable high without latch.");
   property p_latched_read;
      avs_read && avs_waitrequest && in_win(idx, nvm_pkg::OTP_BASE)
         && (otp_state != nvm_pkg::OTP_READ)
      |=> avs_readdata[7:0] == ~otp_mem[$past(idx[7:0])];
   endproperty
   a_latched_read: assert property (p_latched_read)
      else $error("Latched OTP read returned true contents.");
   property p_stop_clears;
      stop_entry |=> (otp_state == nvm_pkg::OTP_READ) && (ee_state == nvm_pkg::EE_READ)
         ##1 !otp_fetch_inhibit && !eeprom_pump_on;
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("Stop entry left a latch set.");
   property p_pgm_after_byte;
      $rose(otp_state == nvm_pkg::OTP_PROG) |-> $past(otp_mask != 8'h00);
   endproperty
   a_pgm_after_byte: assert property (p_pgm_after_byte)
      else $error("Program enable set with no byte loaded.");
   property p_era_frozen;
      ee_sel && $past(ee_sel) && ee_state[nvm_pkg::EE_LATCH_BIT]
      |-> $stable(ee_state[nvm_pkg::EE_ERA_BIT]);
   endproperty
   a_era_frozen: assert property (p_era_frozen)
      else $error("Erase select changed after address latch.");
   property p_pump_needs_data;
      $rose(ee_state[nvm_pkg::EE_PUMP_BIT]) |-> $past(ee_sel);
   endproperty
   a_pump_needs_data: assert property (p_pump_needs_data)
      else $error("Pump switched on before data was selected.");
   property p_pump_held;
      @(posedge ref_clk) disable iff (sys_rst || stop_entry)
      ee_state[nvm_pkg::EE_PUMP_BIT] && !(wr_ctl && !wd[nvm_pkg::EE_LATCH_BIT])
      |=> ee_state[nvm_pkg::EE_PUMP_BIT] ##1 eeprom_pump_on;
   endproperty
   a_pump_held: assert property (p_pump_held)
      else $error("Pump dropped without latch clear.");
   property p_short_hold;
      $fell(sys_rst) && opt.reset_hold_select
      |-> reset_pin_hold [*8] ##1 reset_pin_hold [*8] ##1 !reset_pin_hold;
   endproperty
   a_short_hold: assert property (p_short_hold)
      else $error("Short reset hold length wrong.");
   property p_protected;
      ee_commit && ee_protected && !array_blank |=> $stable(ee_mem[ee_addr]);
   endproperty
   a_protected: assert property (p_protected)
      else $error("Protected EEPROM byte was changed.");
   property p_bus_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("Bus answer not after one wait state.");
   c_otp_commit: cover property (otp_commit);
   c_ee_erase: cover property (ee_commit && ee_state[nvm_pkg::EE_ERA_BIT]);
   c_ee_prog: cover property (ee_commit && !ee_state[nvm_pkg::EE_ERA_BIT] && !ee_protected);
   c_ee_blocked: cover property (ee_commit && ee_protected);
endmodule
`default_nettype wire

// ### common/nvm_pkg.sv
// Shared constants, types and register map of the nonvolatile memory control block.
`default_nettype none
package nvm_pkg;
   localparam int IDX_W = 14;
   // Register indices; the bus byte address is four times the index.
   localparam logic [13:0] CTL_IDX = 14'h0007;
   localparam logic [13:0] EE_BASE = 14'h0100;
   localparam logic [13:0] OTP_BASE = 14'h0200;
   localparam logic [13:0] MOR_IDX = 14'h3dfe;
   // Options byte is EEPROM byte zero, upper region starts at byte 0x20.
   localparam logic [7:0] OPT_OFS = 8'h00;
   localparam logic [7:0] EE_UPPER_OFS = 8'h20;
   localparam int UNLOCK_BIT = 1;
   localparam int LOCK_BIT = 0;
   // Control register field positions.
   localparam int OTP_LATCH_BIT = 5;
   localparam int OTP_PGM_BIT = 4;
   localparam int EE_ERA_BIT = 2;
   localparam int EE_LATCH_BIT = 1;
   localparam int EE_PUMP_BIT = 0;
   localparam logic [7:0] OTP_ERASED = 8'h00;
   localparam logic [7:0] EE_ERASED = 8'hff;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] GROUP_SIZE_M1 = 3'h7;
   // Power-on reset hold lengths in clock cycles.
   localparam logic [11:0] HOLD_SHORT_CYC = 12'h010;
   localparam logic [11:0] HOLD_LONG_CYC = 12'hfe0;

   typedef enum logic [1:0] {
      OTP_READ = 2'b00,
      OTP_LOAD = 2'b10,
      OTP_PROG = 2'b11
   } otp_state_t;

   typedef enum logic [2:0] {
      EE_READ = 3'b000,
      EE_LOAD_PROG = 3'b010,
      EE_PROG = 3'b011,
      EE_LOAD_ERASE = 3'b110,
      EE_ERASE = 3'b111
   } ee_state_t;

   typedef struct packed {
      logic reset_hold_select;
      logic watchdog_after_reset;
      logic watchdog_in_wait;
      logic port_b_pulldown;
      logic port_c_pulldown;
   } factory_opt_t;
endpackage
`default_nettype wire

// ### rtl/reset_hold_timer.sv
// Power-on reset pin hold counter with selectable length.
`timescale 1ns/1ps
`default_nettype none
module reset_hold_timer (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic short_hold,
   output logic hold
);
   logic [11:0] cnt;
   logic [11:0] limit;

   assign limit = short_hold ? nvm_pkg::HOLD_SHORT_CYC : nvm_pkg::HOLD_LONG_CYC;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt <= 12'h000;
         hold <= 1'b1;
      end else if (hold) begin
         cnt <= cnt + 12'h001;
         if (cnt == limit - 12'h001) begin
            hold <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the nonvolatile memory control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [13:0] CTL = nvm_pkg::CTL_IDX;
   localparam logic [13:0] EE = nvm_pkg::EE_BASE;
   localparam logic [13:0] OTP = nvm_pkg::OTP_BASE;
   localparam logic [13:0] FACTORY_OPTION_BITS = nvm_pkg::MOR_IDX;
   logic ref_clk;
   logic sys_rst;
   logic [15:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic stop_entry;
   logic wait_mode;
   logic bootstrap_mode;
   logic array_blank;
   nvm_pkg::factory_opt_t factory_options;
   logic [7:0] port_b_dir;
   logic [7:0] port_c_dir;
   logic otp_program_enable;
   logic otp_fetch_inhibit;
   logic eeprom_pump_on;
   logic non_user_block;
   logic reset_pin_hold;
   logic watchdog_run;
   logic [7:0] port_b_pulldown_en;
   logic [7:0] port_c_pulldown_en;
   int failures;
   int n_compared;

   nvm_program_control dut (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .stop_entry(stop_entry),
      .wait_mode(wait_mode),
      .bootstrap_mode(bootstrap_mode),
      .array_blank(array_blank),
      .factory_options(factory_options),
      .port_b_dir(port_b_dir),
      .port_c_dir(port_c_dir),
      .otp_program_enable(otp_program_enable),
      .otp_fetch_inhibit(otp_fetch_inhibit),
      .eeprom_pump_on(eeprom_pump_on),
      .non_user_block(non_user_block),
      .reset_pin_hold(reset_pin_hold),
      .watchdog_run(watchdog_run),
      .port_b_pulldown_en(port_b_pulldown_en),
      .port_c_pulldown_en(port_c_pulldown_en)
   );

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The release edge is let pass so a following request never reassigns a strobe at once.
   task automatic bus(input logic wr_en, input logic [13:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, d};
      avs_write <= wr_en;
      avs_read <= ~wr_en;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
      if (n >= 20) begin
         failures++;
         $display("mismatch bus_wait expected 0 seen 1");
         close_out();
      end
   endtask

   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rd(input string what, input logic [13:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      check(what, {24'h000000, q}, {24'h000000, exp});
   endtask

   // One load, pump and commit pass on a byte-erasable location.
   task automatic ee_op(input logic [13:0] idx, input logic [7:0] load, input logic [7:0] d);
      wr(CTL, load);
      wr(idx, d);
      wr(CTL, load | 8'h01);
      wr(CTL, 8'h00);
   endtask

   task automatic otp_op(input logic [13:0] idx, input logic [7:0] d);
      wr(CTL, 8'h20);
      wr(idx, d);
      wr(CTL, 8'h30);
      @(posedge ref_clk);
      check("supply_gate", otp_program_enable, 1);
      wr(CTL, 8'h00);
   endtask

   // The hold counter only restarts at a reset release, so the count is taken here.
   task automatic release_reset();
      int n;
      logic hold_seen;
      n = 0;
      sys_rst <= 1'b0;
      array_blank <= 1'b0;
      do begin
         #1;
         hold_seen = (reset_pin_hold === 1'b1);
         if (hold_seen) n++;
         @(posedge ref_clk);
      end while (hold_seen && n < 40);
      @(posedge ref_clk);
      check("reset_hold", n, 16);
   endtask

   initial begin
      failures = 0;
      n_compared = 0;
      sys_rst = 1'b1;
      array_blank = 1'b1;
      avs_address = 16'h0000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hf;
      stop_entry = 1'b0;
      wait_mode = 1'b0;
      bootstrap_mode = 1'b0;
      factory_options = 5'h1b;
      port_b_dir = 8'h0f;
      port_c_dir = 8'h81;
      repeat (3) @(posedge ref_clk);
      release_reset();
      check("watchdog", watchdog_run, 1);
      check("pulldown_b", port_b_pulldown_en, 8'hf0);
      check("pulldown_c", port_c_pulldown_en, 8'h7e);
      check("non_user", non_user_block, 0);
      wait_mode <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check("watchdog_wait", watchdog_run, 0);
      wait_mode <= 1'b0;
      rd("control", CTL, 8'h00);
      rd("factory", FACTORY_OPTION_BITS, 8'h1b);
      wr(FACTORY_OPTION_BITS, 8'h00);
      rd("factory_ro", FACTORY_OPTION_BITS, 8'h1b);
      wr(14'h0008, 8'h55);
      rd("unmapped", 14'h0008, 8'h00);
      rd("otp_blank", OTP + 14'h0008, 8'h00);
      $display("test registers finished");
      wr(CTL, 8'h30);
      rd("control", CTL, 8'h20);
      check("program_pin", otp_program_enable, 0);
      wr(CTL, 8'h20);
      wr(CTL, 8'h30);
      rd("control", CTL, 8'h20);
      check("fetch_inhibit", otp_fetch_inhibit, 1);
      wr(OTP + 14'h0008, 8'ha5);
      wr(OTP + 14'h000f, 8'h3c);
      rd("otp_latched", OTP + 14'h0008, 8'hff);
      wr(CTL, 8'h30);
      rd("control", CTL, 8'h30);
      check("program_pin", otp_program_enable, 1);
      wr(CTL, 8'h20);
      rd("control", CTL, 8'h30);
      wr(CTL, 8'h00);
      rd("control", CTL, 8'h00);
      check("program_pin", otp_program_enable, 0);
      rd("otp_first", OTP + 14'h0008, 8'ha5);
      rd("otp_last", OTP + 14'h000f, 8'h3c);
      otp_op(OTP + 14'h0008, 8'h5a);
      rd("otp_again", OTP + 14'h0008, 8'hff);
      wr(CTL, 8'h22);
      stop_entry <= 1'b1;
      @(posedge ref_clk);
      stop_entry <= 1'b0;
      @(posedge ref_clk);
      rd("control_stop", CTL, 8'h00);
      check("fetch_inhibit", otp_fetch_inhibit, 0);
      $display("test otp finished");
      wr(CTL, 8'h02);
      wr(CTL, 8'h03);
      rd("control", CTL, 8'h02);
      wr(EE + 14'h0010, 8'h3c);
      wr(CTL, 8'h07);
      rd("control", CTL, 8'h03);
      check("pump", eeprom_pump_on, 1);
      wr(CTL, 8'h02);
      rd("control", CTL, 8'h03);
      wr(CTL, 8'h00);
      rd("control", CTL, 8'h00);
      rd("ee_prog", EE + 14'h0010, 8'h3c);
      wr(CTL, 8'h06);
      rd("control", CTL, 8'h06);
      wr(EE + 14'h0010, 8'h00);
      wr(CTL, 8'h07);
      rd("control", CTL, 8'h07);
      wr(CTL, 8'h00);
      rd("ee_erase", EE + 14'h0010, 8'hff);
      $display("test eeprom finished");
      ee_op(EE, 8'h02, 8'hfc);
      rd("options", EE, 8'hfc);
      check("non_user", non_user_block, 0);
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      release_reset();
      check("non_user", non_user_block, 1);
      ee_op(EE + 14'h0030, 8'h02, 8'h00);
      rd("ee_protected", EE + 14'h0030, 8'hff);
      ee_op(EE + 14'h001f, 8'h02, 8'h00);
      rd("ee_lower", EE + 14'h001f, 8'h00);
      bootstrap_mode <= 1'b1;
      ee_op(EE + 14'h0030, 8'h02, 8'h00);
      rd("ee_bootstrap", EE + 14'h0030, 8'h00);
      bootstrap_mode <= 1'b0;
      $display("test protection finished");
      close_out();
   end
endmodule
`default_nettype wire
